/* File: pkg/cmpt_pkg.sv */
// Purpose: Shared constants, types and helpers of the mode/privilege/trap unit
// Assumes: System register numbers are byte addresses (multiples of four)
// Notes:   Mode codes follow the 3-bit mode field of the status upper half
package cmpt_pkg;

    localparam int SR_W     = 32;
    localparam int HALF_W   = 16;
    localparam int SRADDR_W = 10;

    // System register byte addresses
    localparam logic [SRADDR_W-1:0] ADDR_STATUS = 10'h000;
    localparam logic [SRADDR_W-1:0] ADDR_CFG0   = 10'h100;

    // Lower halfword flag positions
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_Q = 4;
    localparam int FLAG_L = 5;
    localparam int FLAG_T = 14;
    localparam int FLAG_R = 15;
    localparam logic [HALF_W-1:0] LO_IMPL_MASK = 16'hc03f;
    localparam logic [HALF_W-1:0] LO_RESET     = 16'h0000;

    // Upper halfword positions (full-word bit numbers)
    localparam int GM_BIT    = 16;
    localparam int IMASK_LSB = 17;
    localparam int IRQ_N     = 4;
    localparam int MODE_LSB  = 22;
    localparam int MODE_W    = 3;
    localparam logic          GM_RESET    = 1'b1;
    localparam logic [IRQ_N-1:0] IMASK_RESET = 4'h0;

    // First configuration register: architecture revision field
    localparam int CFG0_AR_LSB = 13;
    localparam int CFG0_AR_W   = 3;
    localparam logic [CFG0_AR_W-1:0] ARCH_REV = 3'h3;

    // Mode field codes
    localparam logic [MODE_W-1:0] MC_APP  = 3'h0;
    localparam logic [MODE_W-1:0] MC_SUP  = 3'h1;
    localparam logic [MODE_W-1:0] MC_INT0 = 3'h2;
    localparam logic [MODE_W-1:0] MC_INT1 = 3'h3;
    localparam logic [MODE_W-1:0] MC_INT2 = 3'h4;
    localparam logic [MODE_W-1:0] MC_INT3 = 3'h5;
    localparam logic [MODE_W-1:0] MC_EXC  = 3'h6;
    localparam logic [MODE_W-1:0] MC_NMI  = 3'h7;

    // Priority numbers; smaller is more urgent, zero means none
    localparam logic [2:0] PRIO_NONE = 3'h0;
    localparam logic [2:0] PRIO_NMI  = 3'h1;
    localparam logic [2:0] PRIO_EXC  = 3'h2;
    localparam logic [2:0] PRIO_INT3 = 3'h3;
    localparam logic [2:0] PRIO_INT2 = 3'h4;
    localparam logic [2:0] PRIO_INT1 = 3'h5;
    localparam logic [2:0] PRIO_INT0 = 3'h6;

    typedef enum logic [7:0] {
        M_APP  = 8'h01,
        M_SUP  = 8'h02,
        M_INT0 = 8'h04,
        M_INT1 = 8'h08,
        M_INT2 = 8'h10,
        M_INT3 = 8'h20,
        M_EXC  = 8'h40,
        M_NMI  = 8'h80
    } cmpt_mode_t;

    typedef enum logic [2:0] {
        IC_NORMAL = 3'h0,
        IC_SIMD   = 3'h1,
        IC_COPROC = 3'h2,
        IC_JAVA   = 3'h3,
        IC_TLB    = 3'h4,
        IC_CACHE  = 3'h5,
        IC_PRIV   = 3'h6
    } cmpt_iclass_t;

    function automatic logic [MODE_W-1:0] mode_code(input cmpt_mode_t m);
        unique case (m)
            M_APP:   mode_code = MC_APP;
            M_SUP:   mode_code = MC_SUP;
            M_INT0:  mode_code = MC_INT0;
            M_INT1:  mode_code = MC_INT1;
            M_INT2:  mode_code = MC_INT2;
            M_INT3:  mode_code = MC_INT3;
            M_EXC:   mode_code = MC_EXC;
            M_NMI:   mode_code = MC_NMI;
            default: mode_code = MC_SUP;
        endcase
    endfunction

    function automatic cmpt_mode_t code_mode(input logic [MODE_W-1:0] c);
        unique case (c)
            MC_APP:  code_mode = M_APP;
            MC_SUP:  code_mode = M_SUP;
            MC_INT0: code_mode = M_INT0;
            MC_INT1: code_mode = M_INT1;
            MC_INT2: code_mode = M_INT2;
            MC_INT3: code_mode = M_INT3;
            MC_EXC:  code_mode = M_EXC;
            MC_NMI:  code_mode = M_NMI;
        endcase
    endfunction

    function automatic logic [2:0] mode_prio(input cmpt_mode_t m);
        unique case (m)
            M_NMI:   mode_prio = PRIO_NMI;
            M_EXC:   mode_prio = PRIO_EXC;
            M_INT3:  mode_prio = PRIO_INT3;
            M_INT2:  mode_prio = PRIO_INT2;
            M_INT1:  mode_prio = PRIO_INT1;
            M_INT0:  mode_prio = PRIO_INT0;
            default: mode_prio = PRIO_NONE;
        endcase
    endfunction

endpackage

/* File: pkg/cmpt_core_if.sv */
// Purpose: Carrier between the unit top and its decode and arbiter parts
// Assumes: All signals on clk_i, combinational between parts
// Notes:   dec side classifies, arb side chooses the next mode
`timescale 1ns/1ps
interface cmpt_core_if;
    import cmpt_pkg::*;
    logic                 insn_valid;
    cmpt_iclass_t         insn_class;
    logic                 cop_present;
    logic                 privileged;
    logic                 unimpl;
    logic                 priv_viol;
    logic                 nmi;
    logic                 exc;
    logic [IRQ_N-1:0]     irq;
    logic                 gm;
    logic [IRQ_N-1:0]     imask;
    cmpt_mode_t           cur_mode;
    logic                 take;
    cmpt_mode_t           win_mode;

    modport dec_mp (input insn_valid, insn_class, cop_present, privileged,
                    output unimpl, priv_viol);
    modport arb_mp (input nmi, exc, irq, gm, imask, cur_mode,
                    output take, win_mode);
endinterface

/* File: core/cmpt_decode.sv */
// Purpose: Classify an issued instruction as unimplemented or privileged
// Assumes: Instruction class comes from the core decoder
// Notes:   Purely combinational
`timescale 1ns/1ps
module cmpt_decode (
    cmpt_core_if.dec_mp dec
);
    import cmpt_pkg::*;
    logic is_unimpl;

    always_comb begin
        is_unimpl = 1'b0;
        unique case (dec.insn_class)
            IC_SIMD:   is_unimpl = 1'b1;
            IC_TLB:    is_unimpl = 1'b1;
            IC_CACHE:  is_unimpl = 1'b1;
            IC_JAVA:   is_unimpl = 1'b1;
            IC_COPROC: is_unimpl = ~dec.cop_present;
            default:   is_unimpl = 1'b0;
        endcase
        dec.unimpl    = dec.insn_valid & is_unimpl;
        // Unimplemented wins over the privilege check
        dec.priv_viol = dec.insn_valid & ~is_unimpl
                      & (dec.insn_class == IC_PRIV)
                      & ~dec.privileged;
    end
endmodule // cmpt_decode

/* File: core/cmpt_prio.sv */
// Purpose: Pick the most urgent pending event and test it against the mode
// Assumes: Requests are levels on clk_i
// Notes:   Exceptions and NMI ignore the interrupt masks
`timescale 1ns/1ps
module cmpt_prio (
    cmpt_core_if.arb_mp arb
);
    import cmpt_pkg::*;
    cmpt_mode_t cand;
    logic       any;
    logic [2:0] cand_p;
    logic [2:0] cur_p;

    always_comb begin
        any  = 1'b1;
        cand = M_SUP;
        if (arb.nmi) begin
            cand = M_NMI;
        end else if (arb.exc) begin
            cand = M_EXC;
        end else if (arb.irq[3] & ~arb.gm & ~arb.imask[3]) begin
            cand = M_INT3;
        end else if (arb.irq[2] & ~arb.gm & ~arb.imask[2]) begin
            cand = M_INT2;
        end else if (arb.irq[1] & ~arb.gm & ~arb.imask[1]) begin
            cand = M_INT1;
        end else if (arb.irq[0] & ~arb.gm & ~arb.imask[0]) begin
            cand = M_INT0;
        end else begin
            any = 1'b0;
        end
        cand_p = mode_prio(cand);
        cur_p  = mode_prio(arb.cur_mode);
        // Strictly more urgent only; unprioritised modes yield to all
        arb.take = any & ((cur_p == PRIO_NONE) | (cand_p < cur_p));
        arb.win_mode = cand;
    end
endmodule // cmpt_prio

/* File: core/cmpt_top.sv */
// Purpose: Execution mode, privilege checks, status register and traps
// Assumes: Core decoder supplies instruction class; one clock domain
// Notes:   Status and config registers reached by system register port
`timescale 1ns/1ps

module cmpt_top
    import cmpt_pkg::*;
(
    input  wire logic                          clk_i,
    input  wire logic                          resetn_i,
    input  wire logic                          insn_valid_i,
    input  wire cmpt_pkg::cmpt_iclass_t        insn_class_i,
    input  wire logic                          cop_present_i,
    input  wire logic                          nmi_req_i,
    input  wire logic                          exc_req_i,
    input  wire logic [cmpt_pkg::IRQ_N-1:0]    irq_req_i,
    input  wire logic                          scall_i,
    input  wire logic                          ret_i,
    input  wire logic [cmpt_pkg::SR_W-1:0]     ret_status_i,
    input  wire logic                          flag_we_i,
    input  wire logic [cmpt_pkg::HALF_W-1:0]   flag_wdata_i,
    input  wire logic                          sreg_valid_i,
    input  wire logic                          sreg_write_i,
    input  wire logic [cmpt_pkg::SRADDR_W-1:0] sreg_addr_i,
    input  wire logic [cmpt_pkg::SR_W-1:0]     sreg_wdata_i,
    input  wire logic                          mem_valid_i,
    input  wire logic                          mem_protected_i,
    output logic [cmpt_pkg::SR_W-1:0]          sreg_rdata_o,
    output logic                               sreg_deny_o,
    output logic [cmpt_pkg::SR_W-1:0]          processor_status_o,
    output cmpt_pkg::cmpt_mode_t               mode_o,
    output logic                               privileged_o,
    output logic                               unimpl_trap_o,
    output logic                               priv_trap_o,
    output logic                               mem_deny_o,
    output logic                               push_o,
    output logic                               push_gpr_o,
    output logic                               stack_sys_o
);
    import cmpt_pkg::*;

    typedef struct packed {
        logic [HALF_W-1:0] flags;
        logic              gm;
        logic [IRQ_N-1:0]  imask;
        cmpt_mode_t        mode;
        logic [SR_W-1:0]   status;
        logic [SR_W-1:0]   rdata;
        logic              deny;
        logic              unimpl;
        logic              priv;
        logic              mdeny;
        logic              push;
        logic              push_gpr;
        logic              stack_sys;
        logic              privileged;
    } cmpt_state_t;

    function automatic logic [SR_W-1:0] build_status(
        input logic [HALF_W-1:0] fl,
        input logic              g,
        input logic [IRQ_N-1:0]  im,
        input cmpt_mode_t        m
    );
        logic [SR_W-1:0] v;
        v = '0;
        v[HALF_W-1:0]                   = fl & LO_IMPL_MASK;
        v[GM_BIT]                       = g;
        v[IMASK_LSB +: IRQ_N]           = im;
        v[MODE_LSB +: MODE_W]           = mode_code(m);
        build_status = v;
    endfunction

    localparam cmpt_state_t RESET_STATE = '{
        flags:      LO_RESET,
        gm:         GM_RESET,
        imask:      IMASK_RESET,
        mode:       M_SUP,
        status:     build_status(LO_RESET, GM_RESET, IMASK_RESET, M_SUP),
        rdata:      '0,
        deny:       1'b0,
        unimpl:     1'b0,
        priv:       1'b0,
        mdeny:      1'b0,
        push:       1'b0,
        push_gpr:   1'b0,
        stack_sys:  1'b1,
        privileged: 1'b1
    };

    cmpt_state_t s_q;
    cmpt_state_t s_d;
    cmpt_core_if cif ();

    logic            priv_now;
    logic            sr_hit;
    logic            cfg_hit;
    logic            sreg_deny;
    logic            mem_deny;
    logic [SR_W-1:0] cfg0_val;

    cmpt_decode u_decode (
        .dec (cif.dec_mp)
    );

    cmpt_prio u_prio (
        .arb (cif.arb_mp)
    );

    always_comb begin
        cfg0_val = '0;
        cfg0_val[CFG0_AR_LSB +: CFG0_AR_W] = ARCH_REV;
    end

    assign priv_now  = (s_q.mode != M_APP);
    assign sr_hit    = (sreg_addr_i == ADDR_STATUS);
    assign cfg_hit   = (sreg_addr_i == ADDR_CFG0);
    // Application code may only reach the status register (low half)
    assign sreg_deny = sreg_valid_i & ~priv_now & ~sr_hit;
    assign mem_deny  = mem_valid_i & mem_protected_i & ~priv_now;

    // Decoder is revision-independent so older binaries behave the same
    assign cif.insn_valid  = insn_valid_i;
    assign cif.insn_class  = insn_class_i;
    assign cif.cop_present = cop_present_i;
    assign cif.privileged  = priv_now;
    assign cif.nmi         = nmi_req_i;
    // Local violations are processed as exceptions in the same cycle
    assign cif.exc         = exc_req_i | cif.unimpl | cif.priv_viol
                           | sreg_deny | mem_deny;
    assign cif.irq         = irq_req_i;
    assign cif.gm          = s_q.gm;
    assign cif.imask       = s_q.imask;
    assign cif.cur_mode    = s_q.mode;

    always_comb begin
        s_d          = s_q;
        s_d.rdata    = s_q.rdata;
        s_d.deny     = sreg_deny;
        s_d.unimpl   = cif.unimpl;
        s_d.priv     = cif.priv_viol;
        s_d.mdeny    = mem_deny;
        s_d.push     = 1'b0;
        s_d.push_gpr = 1'b0;

        if (flag_we_i) begin
            s_d.flags = flag_wdata_i & LO_IMPL_MASK;
        end

        if (sreg_valid_i & ~sreg_write_i) begin
            if (sr_hit & priv_now) begin
                s_d.rdata = s_q.status;
            end else if (sr_hit) begin
                s_d.rdata = {{HALF_W{1'b0}}, s_q.status[HALF_W-1:0]};
            end else if (cfg_hit & priv_now) begin
                s_d.rdata = cfg0_val;
            end else begin
                s_d.rdata = '0;
            end
        end

        if (sreg_valid_i & sreg_write_i & sr_hit) begin
            s_d.flags = sreg_wdata_i[HALF_W-1:0] & LO_IMPL_MASK;
            if (priv_now) begin
                s_d.gm    = sreg_wdata_i[GM_BIT];
                s_d.imask = sreg_wdata_i[IMASK_LSB +: IRQ_N];
                s_d.mode  = code_mode(
                    sreg_wdata_i[MODE_LSB +: MODE_W]);
            end
        end

        // Event order: accepted event, then return, then system call
        if (cif.take) begin
            s_d.mode     = cif.win_mode;
            s_d.push     = 1'b1;
            s_d.push_gpr = (cif.win_mode != M_EXC);
        end else if (ret_i & priv_now) begin
            s_d.flags = ret_status_i[HALF_W-1:0] & LO_IMPL_MASK;
            s_d.gm    = ret_status_i[GM_BIT];
            s_d.imask = ret_status_i[IMASK_LSB +: IRQ_N];
            s_d.mode  = code_mode(ret_status_i[MODE_LSB +: MODE_W]);
        end else if (scall_i & (s_q.mode == M_APP || s_q.mode == M_SUP)) begin
            s_d.mode = M_SUP;
            s_d.push = 1'b1;
        end

        s_d.status     = build_status(s_d.flags, s_d.gm, s_d.imask,
                                      s_d.mode);
        s_d.stack_sys  = (s_d.mode != M_APP);
        s_d.privileged = (s_d.mode != M_APP);
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            s_q <= RESET_STATE;
        end else begin
            s_q <= s_d;
        end
    end

    assign sreg_rdata_o       = s_q.rdata;
    assign sreg_deny_o        = s_q.deny;
    assign processor_status_o = s_q.status;
    assign mode_o             = s_q.mode;
    assign privileged_o       = s_q.privileged;
    assign unimpl_trap_o      = s_q.unimpl;
    assign priv_trap_o        = s_q.priv;
    assign mem_deny_o         = s_q.mdeny;
    assign push_o             = s_q.push;
    assign push_gpr_o         = s_q.push_gpr;
    assign stack_sys_o        = s_q.stack_sys;

endmodule // cmpt_top

/* File: sim/cmpt_top_properties.sv */
// Purpose: Port-level checks of the mode, privilege and trap unit
// Assumes: Single clock, synchronous active-low reset
// Notes:   Bound into every cmpt_top instance
`timescale 1ns/1ps
module cmpt_top_properties
    import cmpt_pkg::*;
(
    input wire logic                          clk_i,
    input wire logic                          resetn_i,
    input wire logic                          insn_valid_i,
    input wire cmpt_pkg::cmpt_iclass_t        insn_class_i,
    input wire logic                          cop_present_i,
    input wire logic                          nmi_req_i,
    input wire logic                          exc_req_i,
    input wire logic [cmpt_pkg::IRQ_N-1:0]    irq_req_i,
    input wire logic                          scall_i,
    input wire logic                          ret_i,
    input wire logic [cmpt_pkg::SR_W-1:0]     ret_status_i,
    input wire logic                          flag_we_i,
    input wire logic [cmpt_pkg::HALF_W-1:0]   flag_wdata_i,
    input wire logic                          sreg_valid_i,
    input wire logic                          sreg_write_i,
    input wire logic [cmpt_pkg::SRADDR_W-1:0] sreg_addr_i,
    input wire logic [cmpt_pkg::SR_W-1:0]     sreg_wdata_i,
    input wire logic                          mem_valid_i,
    input wire logic                          mem_protected_i,
    input wire logic [cmpt_pkg::SR_W-1:0]     sreg_rdata_o,
    input wire logic                          sreg_deny_o,
    input wire logic [cmpt_pkg::SR_W-1:0]     processor_status_o,
    input wire cmpt_pkg::cmpt_mode_t          mode_o,
    input wire logic                          privileged_o,
    input wire logic                          unimpl_trap_o,
    input wire logic                          priv_trap_o,
    input wire logic                          mem_deny_o,
    input wire logic                          push_o,
    input wire logic                          push_gpr_o,
    input wire logic                          stack_sys_o
);
    import cmpt_pkg::*;
    default clocking cb @(posedge clk_i); endclocking

    AST_UNIMPL: assert property (disable iff (!resetn_i)
        insn_valid_i && insn_class_i inside {IC_SIMD, IC_JAVA, IC_TLB,
        IC_CACHE} |=> unimpl_trap_o) else $error("unimplemented not trapped");
    AST_COPROC: assert property (disable iff (!resetn_i)
        insn_valid_i && insn_class_i == IC_COPROC
        |=> unimpl_trap_o == !$past(cop_present_i))
        else $error("coprocessor trap wrong");
    AST_APP_PRIV: assert property (disable iff (!resetn_i)
        insn_valid_i && insn_class_i == IC_PRIV && mode_o == M_APP
        |=> priv_trap_o) else $error("privileged insn not refused");
    AST_RESET: assert property (
        !resetn_i |=> mode_o == M_SUP && !push_o && stack_sys_o
        && processor_status_o[15:0] == LO_RESET)
        else $error("reset state wrong");
    AST_PRIV_OUT: assert property (disable iff (!resetn_i)
        privileged_o == (mode_o != M_APP)) else $error("privileged flag wrong");
    AST_STACK: assert property (disable iff (!resetn_i)
        stack_sys_o == (mode_o != M_APP)) else $error("stack select wrong");
    AST_GPR_PUSH: assert property (disable iff (!resetn_i)
        push_gpr_o |-> push_o) else $error("register push without frame");
    AST_MEM: assert property (disable iff (!resetn_i)
        mem_valid_i && mem_protected_i
        |=> mem_deny_o == ($past(mode_o) == M_APP))
        else $error("memory deny wrong");
    AST_SREG_DENY: assert property (disable iff (!resetn_i)
        sreg_valid_i && mode_o == M_APP && sreg_addr_i != ADDR_STATUS
        |=> sreg_deny_o && ($past(sreg_write_i) || sreg_rdata_o == '0))
        else $error("sysreg not denied");
    AST_EXC_HOLD: assert property (disable iff (!resetn_i)
        mode_o == M_EXC && !ret_i && !sreg_valid_i
        |=> mode_o inside {M_EXC, M_NMI}) else $error("lower mode preempted");
    AST_NMI_HOLD: assert property (disable iff (!resetn_i)
        mode_o == M_NMI && !ret_i && !sreg_valid_i |=> $stable(mode_o))
        else $error("nmi mode preempted");
endmodule // cmpt_top_properties

bind cmpt_top cmpt_top_properties cmpt_top_properties_inst (.*);

/* File: sim/tb_top.sv */
// Purpose: Directed test of modes, privilege checks and traps
// Assumes: Fixed one-cycle answers of the unit
// Notes:   Inputs change a fixed delay after the rising edge
`timescale 1ns/1ps
module tb_top;
    import cmpt_pkg::*;
    localparam time DLY = 2ns;
    logic                clk_i           = 1'b0;
    logic                resetn_i        = 1'b0;
    logic                insn_valid_i    = 1'b0;
    cmpt_iclass_t        insn_class_i    = IC_NORMAL;
    logic                cop_present_i   = 1'b0;
    logic                nmi_req_i       = 1'b0;
    logic                exc_req_i       = 1'b0;
    logic [IRQ_N-1:0]    irq_req_i       = '0;
    logic                scall_i         = 1'b0;
    logic                ret_i           = 1'b0;
    logic [SR_W-1:0]     ret_status_i    = '0;
    logic                flag_we_i       = 1'b0;
    logic [HALF_W-1:0]   flag_wdata_i    = '0;
    logic                sreg_valid_i    = 1'b0;
    logic                sreg_write_i    = 1'b0;
    logic [SRADDR_W-1:0] sreg_addr_i     = '0;
    logic [SR_W-1:0]     sreg_wdata_i    = '0;
    logic                mem_valid_i     = 1'b0;
    logic                mem_protected_i = 1'b0;
    logic [SR_W-1:0]     sreg_rdata_o, processor_status_o, r_data;
    cmpt_mode_t          mode_o, r_mode;
    logic                sreg_deny_o, privileged_o, unimpl_trap_o;
    logic                priv_trap_o, mem_deny_o, push_o, push_gpr_o;
    logic                stack_sys_o, r_deny, r_unimpl, r_priv, r_push, r_gpr;
    int                  failures        = 0;
    int                  n_tests         = 0;
    cmpt_iclass_t        bad[5] = '{IC_SIMD, IC_COPROC, IC_JAVA, IC_TLB,
                                    IC_CACHE};
    cmpt_iclass_t        good[3] = '{IC_COPROC, IC_NORMAL, IC_PRIV};
    // Event table: {nmi, exc, irq[3:0]}, expected mode, {push, push_gpr}
    logic [5:0]          ev[9] = '{6'h01, 6'h03, 6'h01, 6'h05, 6'h09,
                                   6'h19, 6'h30, 6'h1f, 6'h00};
    cmpt_mode_t          em[9] = '{M_INT0, M_INT1, M_INT1, M_INT2, M_INT3,
                                   M_EXC, M_NMI, M_NMI, M_NMI};
    logic [1:0]          ep[9] = '{2'h3, 2'h3, 2'h0, 2'h3, 2'h3, 2'h2,
                                   2'h3, 2'h0, 2'h0};

    cmpt_top cmpt_top_inst (.*);

    always #12.5 clk_i = ~clk_i;

    task automatic report_and_stop();
        if (failures == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Lets one edge pass without touching the captured answers
    task automatic idle();
        @(posedge clk_i);
        #DLY;
    endtask

    // Takes the edge, then captures every one-cycle answer except mem_deny_o
    task automatic step();
        idle();
        r_data   = sreg_rdata_o;
        r_deny   = sreg_deny_o;
        r_unimpl = unimpl_trap_o;
        r_priv   = priv_trap_o;
        r_mode   = mode_o;
        r_push   = push_o;
        r_gpr    = push_gpr_o;
    endtask

    task automatic sreg(input logic wr, input logic [SRADDR_W-1:0] a,
                        input logic [SR_W-1:0] d);
        sreg_valid_i = 1'b1;
        sreg_write_i = wr;
        sreg_addr_i  = a;
        sreg_wdata_i = d;
        step();
        sreg_valid_i = 1'b0;
        idle();
    endtask

    task automatic insn(input cmpt_iclass_t c);
        insn_valid_i = 1'b1;
        insn_class_i = c;
        step();
        insn_valid_i = 1'b0;
        idle();
    endtask

    task automatic ret(input logic [SR_W-1:0] s);
        ret_i        = 1'b1;
        ret_status_i = s;
        step();
        ret_i = 1'b0;
        idle();
    endtask

    initial begin
        repeat (4000) @(posedge clk_i);
        failures++;
        report_and_stop();
    end

    initial begin
        repeat (16) @(posedge clk_i);
        #DLY;
        resetn_i = 1'b1;
        step();
        check(32'(mode_o), 32'(M_SUP));
        check(processor_status_o, 32'h0041_0000);
        check(32'({privileged_o, stack_sys_o}), 32'h3);
        sreg(1'b0, ADDR_CFG0, '0);
        check(32'(r_data[15:13]), 32'(ARCH_REV));
        sreg(1'b1, ADDR_CFG0, 32'hffff_ffff);
        sreg(1'b0, ADDR_CFG0, '0);
        check(32'(r_data[15:13]), 32'(ARCH_REV));
        flag_we_i    = 1'b1;
        flag_wdata_i = 16'hffff;
        step();
        flag_we_i = 1'b0;
        step();
        check(32'(processor_status_o[15:0]), 32'(LO_IMPL_MASK));
        check(32'(processor_status_o[31:16]), 32'h0041);
        // Second reset in mid-run must clear the flags again
        resetn_i = 1'b0;
        step();
        resetn_i = 1'b1;
        step();
        check(processor_status_o, 32'h0041_0000);
        foreach (bad[i]) begin
            insn(bad[i]);
            check(32'(r_unimpl), 32'h1);
            check(32'(r_mode), 32'(M_EXC));
            check(32'({r_push, r_gpr}), 32'h2);
            ret(32'h0041_0000);
            check(32'(mode_o), 32'(M_SUP));
        end
        cop_present_i = 1'b1;
        foreach (good[i]) begin
            insn(good[i]);
            check(32'({r_unimpl, r_priv, r_push}), 32'h0);
        end
        cop_present_i = 1'b0;
        sreg(1'b1, ADDR_STATUS, 32'h0040_0000);
        check(processor_status_o, 32'h0040_0000);
        foreach (ev[i]) begin
            {nmi_req_i, exc_req_i, irq_req_i} = ev[i];
            step();
            check(32'(r_mode), 32'(em[i]));
            check(32'({r_push, r_gpr}), 32'(ep[i]));
        end
        ret(32'h0040_0000);
        sreg(1'b1, ADDR_STATUS, 32'h0000_0000);
        check(32'(mode_o), 32'(M_APP));
        check(32'({privileged_o, stack_sys_o}), 32'h0);
        sreg(1'b1, ADDR_STATUS, 32'h01c0_0000);
        check(32'(mode_o), 32'(M_APP));
        sreg(1'b0, ADDR_CFG0, '0);
        check(32'(r_deny), 32'h1);
        check(r_data, 32'h0);
        ret(32'h0);
        insn(IC_PRIV);
        check(32'(r_priv), 32'h1);
        ret(32'h0);
        mem_valid_i     = 1'b1;
        mem_protected_i = 1'b1;
        step();
        check(32'(mem_deny_o), 32'h1);
        mem_valid_i = 1'b0;
        step();
        ret(32'h0);
        check(32'(mode_o), 32'(M_APP));
        scall_i = 1'b1;
        step();
        check(32'(r_mode), 32'(M_SUP));
        check(32'({r_push, r_gpr}), 32'h2);
        scall_i = 1'b0;
        step();
        report_and_stop();
    end
endmodule // tb_top
